// ---- inc/spc_pkg.sv ----
// What this block does
// - bit_order_select 0 sends MSB first, 1 sends LSB first
// - master with SS input low and not ignored drops to slave, sets flag
// - select_line_ignore 1 keeps master operation whatever SS does
// - sck_rate_double doubles the prescaled SCK rate in master operation
// - sck_rate_divider picks peripheral_clock divide by 4, 16, 64 or 128
// - enable bit 1 turns the SPI on, 0 turns it off
// - buffered_operation_on gives two rx buffers, one tx buffer, split flags
// - wait-first-receive 0: buffer moves after one transfer, first is dummy
// - wait-first-receive 1: first write with SS high loads shifter directly
// - mode field picks SCK polarity and sample or setup on leading edge
// - SCK idles low for rising-lead modes, high for falling-lead modes
// - four buffered irq enables act only buffered, read zero otherwise
// - unbuffered, legacy_irq_on raises irq while the transfer flag is set
// - buffered, rx flag set while rx data unread, clears when empty
// - buffered, rx flag also cleared by writing one to it
// - unbuffered, transfer flag set when a whole byte has shifted
// - unbuffered flag cleared by vector ack or flag read then data access
// - irq stays high while an enabled flag stays set
// - unbuffered, data write during a transfer sets the collision flag
// - buffered, holding-empty clears on data write unless loaded direct, sets when moved
// - buffered, overrun set when both rx buffers full and third arrives
package spc_pkg;
  localparam int ADDR_W = 3;
  localparam logic [2:0] A_CORE = 3'h0;
  localparam logic [2:0] A_MODE = 3'h1;
  localparam logic [2:0] A_IEN = 3'h2;
  localparam logic [2:0] A_FLAG = 3'h3;
  localparam logic [2:0] A_DATA = 3'h4;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] CORE_MASK = 8'h77;
  localparam logic [7:0] MODE_MASK = 8'hC7;
  localparam logic [7:0] IEN_MASK = 8'hF1;
  localparam int B_BIT_ORDER_SELECT = 6;
  localparam int B_MST = 5;
  localparam int B_DBL = 4;
  localparam int B_PRE = 1;
  localparam int B_EN = 0;
  localparam int B_BUF = 7;
  localparam int B_BWR = 6;
  localparam int B_SSD = 2;
  localparam int B_CPOL = 1;
  localparam int B_CPHA = 0;
  localparam int F_RXC = 7;
  localparam int F_TXC = 6;
  localparam int F_DRE = 5;
  localparam int F_SSI = 4;
  localparam int F_OVF = 0;
  localparam int IE_LEG = 0;
  // half of each SCK period, in peripheral clocks
  localparam logic [6:0] HALF_DIV4 = 7'h02;
  localparam logic [6:0] HALF_DIV16 = 7'h08;
  localparam logic [6:0] HALF_DIV64 = 7'h20;
  localparam logic [6:0] HALF_DIV128 = 7'h40;
  localparam logic [3:0] LAST_EDGE = 4'hF;
  localparam logic [1:0] RX_FULL = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_MXFER = 3'h2,
    ST_SXFER = 3'h4
  } spc_state_t;
endpackage

// ---- inc/spc_rate_if.sv ----
`timescale 1ns/1ps
interface spc_rate_if;
  logic [1:0] sck_rate_divider;
  logic dbl;
  logic run;
  logic tick;
  modport gen (input sck_rate_divider, input dbl, input run, output tick);
  modport user (output sck_rate_divider, output dbl, output run, input tick);
endinterface // spc_rate_if

// ---- hdl/spc_sck_div.sv ----
`timescale 1ns/1ps
module spc_sck_div #(
  parameter int CNT_W = 7
) (
  input wire logic mclk,
  input wire logic rst_n,
  spc_rate_if.gen rate
);
  import spc_pkg::*;

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] gap;
  logic gap_ok;
  logic [6:0] half_base;
  logic [CNT_W-1:0] half;
  wire at_end = (cnt == half - CNT_W'(1));

  assign half_base = (rate.sck_rate_divider == 2'h0) ? HALF_DIV4 :
                     (rate.sck_rate_divider == 2'h1) ? HALF_DIV16 :
                     (rate.sck_rate_divider == 2'h2) ? HALF_DIV64 : HALF_DIV128;
  // doubling halves each SCK half period
  assign half = rate.dbl ? CNT_W'(half_base >> 1) : CNT_W'(half_base);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      rate.tick <= 1'b0;
    end else if (!rate.run || at_end) begin
      cnt <= '0;
      rate.tick <= rate.run;
    end else begin
      cnt <= cnt + CNT_W'(1);
      rate.tick <= 1'b0;
    end
  end

  // helper: cycles since the previous tick
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gap <= '0;
      gap_ok <= 1'b0;
    end else begin
      gap <= rate.tick ? '0 : gap + CNT_W'(1);
      gap_ok <= rate.run && (gap_ok || rate.tick);
    end
  end

  a_tick_gap: assert property (
    @(posedge mclk) disable iff (!rst_n)
    rate.tick && gap_ok && $stable(half) && $past(rate.run)
      |-> gap == half - CNT_W'(1))
    else $error("sck half period differs from the selected rate");
endmodule // spc_sck_div

// ---- hdl/spc_ctl.sv ----
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module spc_ctl (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [spc_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic ss_is_input,
  input wire logic ss_pin,
  input wire logic irq_ack,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  output logic irq
);
  import spc_pkg::*;

  logic [7:0] core;
  logic [7:0] mcfg;
  logic [7:0] ien;
  logic f_rxc;
  logic f_txc;
  logic f_ssi;
  logic f_ovf;
  logic arm_rxc;
  logic arm_txc;
  logic [7:0] sh;
  logic [7:0] txb;
  logic [7:0] rx1;
  logic [7:0] rx2;
  logic txb_full;
  logic inb;
  logic [1:0] rxcnt;
  logic [3:0] ecnt;
  spc_state_t state;
  spc_state_t next_state;
  logic ss_q1;
  logic ss_q2;
  logic sck_q1;
  logic sck_q2;
  logic sck_q3;
  logic mosi_q1;
  logic mosi_q2;
  logic miso_q1;
  logic miso_q2;

  spc_rate_if rate_if ();

  spc_sck_div #(.CNT_W(7)) u_div (
    .mclk(mclk),
    .rst_n(rst_n),
    .rate(rate_if.gen)
  );

  function automatic logic [7:0] shf(input logic [7:0] v, input logic b,
                                     input logic lsb);
    shf = lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  wire en = core[B_EN];
  wire mst = core[B_MST];
  wire bit_order_select = core[B_BIT_ORDER_SELECT];
  wire buf_on = mcfg[B_BUF];
  wire bwr = mcfg[B_BWR];
  wire select_line_ignore = mcfg[B_SSD];
  wire cpol = mcfg[B_CPOL];
  wire cpha = mcfg[B_CPHA];
  wire idle = (state == ST_IDLE);
  wire m_busy = (state == ST_MXFER);
  wire s_busy = (state == ST_SXFER);

  assign rate_if.sck_rate_divider = core[B_PRE +: 2];
  assign rate_if.dbl = core[B_DBL];
  assign rate_if.run = m_busy;

  wire wr_core = wr && (addr == A_CORE);
  wire wr_mode = wr && (addr == A_MODE);
  wire wr_ien = wr && (addr == A_IEN);
  wire wr_flag = wr && (addr == A_FLAG);
  wire wr_data = wr && (addr == A_DATA) && en;
  wire rd_flag = rd && (addr == A_FLAG);
  wire acc_data = (wr || rd) && (addr == A_DATA);

  // SS low forces master back to slave
  wire fault = en && mst && ss_is_input && !select_line_ignore && !ss_q2;

  // edges from the divider or the synced SCK pin
  wire edge_ev = (m_busy && rate_if.tick) || (s_busy && (sck_q2 ^ sck_q3));
  wire ein = m_busy ? miso_q2 : mosi_q2;
  wire sample = edge_ev && (ecnt[0] == cpha);
  wire setup = edge_ev && !sample;
  wire done = edge_ev && (ecnt == LAST_EDGE);
  wire [7:0] rx_byte = shf(sh, cpha ? ein : inb, bit_order_select);
  // outgoing bit taken from the end chosen by bit order
  wire outb = bit_order_select ? sh[0] : sh[7];

  wire reload = buf_on && txb_full;
  // first write with SS high goes straight to the shifter
  wire direct = buf_on && bwr && ss_q2 && idle && !txb_full;
  // otherwise a buffered write waits in the holding register
  wire accept_buf = wr_data && buf_on && !txb_full && !direct;
  wire load_now = wr_data && idle && (!buf_on || direct);
  wire m_start = mst && idle && wr_data && (!buf_on || !txb_full);
  // write while a byte is still shifting
  wire coll = wr_data && !buf_on && !idle;
  wire dre = buf_on && !txb_full;

  wire rx_pop = rd && (addr == A_DATA) && buf_on && (rxcnt != 2'h0);
  wire rx_push = done && buf_on && ((rxcnt != RX_FULL) || rx_pop);
  wire ovf_ev = done && buf_on && (rxcnt == RX_FULL) && !rx_pop;
  wire [1:0] cnt_pop = rxcnt - {1'b0, rx_pop};

  // buffered rx flag follows unread data
  wire rx_empty = rx_pop && (rxcnt == 2'h1) && !rx_push;
  wire w1c_rxc = wr_flag && wdata[F_RXC];
  wire w1c_txc = wr_flag && wdata[F_TXC];
  wire w1c_ssi = wr_flag && wdata[F_SSI];
  // transfer end, or mode fault in unbuffered operation
  wire set_rxc = done || (fault && !buf_on);
  // unbuffered: vector ack, or flag read then data access; buffered: write one or empty
  wire clr_rxc = buf_on ? (w1c_rxc || rx_empty)
                        : (irq_ack || (arm_rxc && acc_data));
  wire set_txc = buf_on ? (done && !reload) : coll;
  wire clr_txc = buf_on ? w1c_txc : (arm_txc && acc_data);

  // buffered enables only count in buffered operation
  wire [3:0] src_buf = ien[7:4] & {f_rxc, f_txc, dre, f_ssi};
  // level request while an enabled flag is set
  wire irq_src = buf_on ? (|src_buf) : (ien[IE_LEG] && f_rxc);

  wire [7:0] flags_rd = buf_on ? {f_rxc, f_txc, dre, f_ssi, 3'h0, f_ovf}
                               : {f_rxc, f_txc, 6'h00};
  wire [7:0] ien_rd = buf_on ? ien : {4'h0, ien[3:0]};
  wire [7:0] rd_mux = (addr == A_CORE) ? core :
                      (addr == A_MODE) ? mcfg :
                      (addr == A_IEN) ? ien_rd :
                      (addr == A_FLAG) ? flags_rd :
                      (addr == A_DATA) ? rx2 : 8'h00;

  // pin synchronisers; the first stage feeds only the second
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {ss_q1, ss_q2} <= 2'h3;
      {sck_q1, sck_q2, sck_q3} <= 3'h0;
      {mosi_q1, mosi_q2, miso_q1, miso_q2} <= 4'h0;
    end else begin
      {ss_q1, ss_q2} <= {ss_pin, ss_q1};
      {sck_q1, sck_q2, sck_q3} <= {sck_i, sck_q1, sck_q2};
      {mosi_q1, mosi_q2} <= {mosi_i, mosi_q1};
      {miso_q1, miso_q2} <= {miso_i, miso_q1};
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (m_start) begin
          next_state = ST_MXFER;
        end else if (!mst && !ss_q2) begin
          next_state = ST_SXFER;
        end
      end
      ST_MXFER: begin
        if (fault || (done && !reload)) begin
          next_state = ST_IDLE;
        end
      end
      // SS high halts the slave, a partial byte is lost
      ST_SXFER: begin
        if (ss_q2) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (!en) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      ecnt <= 4'h0;
    end else begin
      state <= next_state;
      ecnt <= idle ? 4'h0 : (edge_ev ? ecnt + 4'h1 : ecnt);
    end
  end

  // capture on sample edges, shift on setup edges
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sh <= 8'h00;
      inb <= 1'b0;
    end else begin
      if (sample) begin
        inb <= ein;
      end
      if (load_now) begin
        sh <= wdata;
      end else if (done) begin
        sh <= reload ? txb : rx_byte;
      end else if (setup && (ecnt != 4'h0)) begin
        sh <= shf(sh, inb, bit_order_select);
      end
    end
  end

  // holding register empties into the shifter at byte end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      txb <= 8'h00;
      txb_full <= 1'b0;
    end else begin
      if (done && reload) begin
        txb_full <= 1'b0;
      end
      if (accept_buf) begin
        txb <= wdata;
        txb_full <= 1'b1;
      end
    end
  end

  // reading moves the first rx buffer into the second
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx1 <= 8'h00;
      rx2 <= 8'h00;
      rxcnt <= 2'h0;
    end else begin
      if (rx_pop && (rxcnt == RX_FULL)) begin
        rx2 <= rx1;
      end
      if (done && !buf_on) begin
        rx2 <= rx_byte;
      end else if (rx_push && (cnt_pop == 2'h0)) begin
        rx2 <= rx_byte;
      end else if (rx_push) begin
        rx1 <= rx_byte;
      end
      rxcnt <= buf_on ? cnt_pop + {1'b0, rx_push} : 2'h0;
    end
  end

  // hardware set wins over any clear in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {f_rxc, f_txc, f_ssi, f_ovf} <= 4'h0;
      {arm_rxc, arm_txc} <= 2'h0;
    end else begin
      f_rxc <= set_rxc || (f_rxc && !clr_rxc);
      f_txc <= set_txc || (f_txc && !clr_txc);
      f_ssi <= (fault && buf_on) || (f_ssi && !w1c_ssi);
      f_ovf <= ovf_ev || (f_ovf && !rx_pop);
      if (rd_flag) begin
        arm_rxc <= f_rxc && !buf_on;
        arm_txc <= f_txc && !buf_on;
      end else if (acc_data) begin
        {arm_rxc, arm_txc} <= 2'h0;
      end
    end
  end

  // fault clears master; only software sets it again
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      core <= REG_RST;
      mcfg <= REG_RST;
      ien <= REG_RST;
    end else begin
      if (wr_core) begin
        core <= wdata & CORE_MASK;
      end
      if (fault) begin
        core[B_MST] <= 1'b0;
      end
      if (wr_mode) begin
        mcfg <= wdata & MODE_MASK;
      end
      if (wr_ien) begin
        ien <= wdata & IEN_MASK;
      end
    end
  end

  // pins; SCK rests at the polarity level
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sck_o <= 1'b0;
      {sck_oe, mosi_oe, miso_oe} <= 3'h0;
      {mosi_o, miso_o, irq} <= 3'h0;
      rdata <= 8'h00;
    end else begin
      sck_o <= m_busy ? (sck_o ^ rate_if.tick) : cpol;
      sck_oe <= en && mst;
      mosi_oe <= en && mst;
      miso_oe <= en && !mst && !ss_q2;
      mosi_o <= outb;
      miso_o <= outb;
      irq <= irq_src;
      rdata <= rd ? rd_mux : 8'h00;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_fault_plain;
    fault && !buf_on && !wr_mode && !wr_core;
  endsequence

  sequence s_idle_pair;
    (state != ST_MXFER) ##1 $stable(cpol);
  endsequence

  sequence s_lsb_load;
    (load_now && bit_order_select) ##1 (bit_order_select && !setup);
  endsequence

  a_mode_fault: assert property (
    s_fault_plain |=> !core[B_MST] && f_rxc)
    else $error("ss fault did not drop master and set flag");

  a_ssd_hold: assert property (
    mst && select_line_ignore && !wr_core |=> core[B_MST])
    else $error("master lost while select line ignored");

  a_sck_idle: assert property (
    s_idle_pair |-> sck_o == cpol)
    else $error("sck not at idle polarity");

  a_quiet_off: assert property (
    !en |=> !sck_oe && !mosi_oe && !miso_oe)
    else $error("pin driven while disabled");

  a_lsb_first: assert property (
    s_lsb_load |=> mosi_o == $past(wdata[0], 2))
    else $error("first bit out is not the lsb");

  a_ien_hide: assert property (
    rd && (addr == A_IEN) && !buf_on |=> rdata[7:4] == 4'h0)
    else $error("buffered enables visible when unbuffered");

  a_legacy_irq: assert property (
    !buf_on && ien[IE_LEG] && f_rxc |=> irq)
    else $error("legacy irq missing");

  a_irq_quiet: assert property (
    (ien == 8'h00) [*2] |-> !irq)
    else $error("irq without an enabled source");

  a_xfer_flag: assert property (
    done && !buf_on |=> f_rxc)
    else $error("transfer flag not set at byte end");

  a_collide: assert property (
    coll |=> f_txc)
    else $error("collision not flagged");

  a_dre_low: assert property (
    accept_buf |=> !dre)
    else $error("holding empty still set after write");

  a_overrun: assert property (
    ovf_ev |=> f_ovf ##1 (f_ovf || $past(rx_pop)))
    else $error("overrun not flagged");
endmodule // spc_ctl

// ---- dv/spc_spi_peer.sv ----
`timescale 1ns/1ps
module spc_spi_peer (
  input wire logic mclk,
  input wire logic active,
  input wire logic [1:0] mode,
  input wire logic lsb_first,
  input wire logic sck,
  input wire logic mosi,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte
);
  logic last_sck = 1'b0;
  logic armed = 1'b0;
  logic [2:0] scnt = 3'h0;
  logic [2:0] rcnt = 3'h0;
  logic [7:0] rx_sh = 8'h00;
  logic lead;
  initial miso = 1'b0;
  initial rx_byte = 8'h00;
  function automatic logic bit_at(input logic [2:0] i);
    return lsb_first ? tx_byte[i] : tx_byte[3'h7 - i];
  endfunction
  // sample mosi, set up miso on the mode's edges
  always @(posedge mclk or sck) begin
    lead = (sck != mode[1]);
    if (!active) begin
      // deselected: keep toggling so stale data never passes
      if (sck === last_sck) miso = ~miso;
      armed = 1'b0;
      scnt = 3'h0;
      rcnt = 3'h0;
    end else if (sck !== last_sck) begin
      if (lead != mode[0]) begin
        rx_sh[lsb_first ? rcnt : 3'h7 - rcnt] = mosi;
        rcnt = rcnt + 3'h1;
        if (rcnt == 3'h0) rx_byte = rx_sh;
      end else begin
        miso = bit_at(scnt);
        scnt = scnt + 3'h1;
      end
    end else if (!armed) begin
      armed = 1'b1;
      // sample-first modes need bit one before the first edge
      if (!mode[0]) begin
        miso = bit_at(3'h0);
        scnt = 3'h1;
      end
    end
    last_sck = sck;
  end
endmodule // spc_spi_peer

// ---- dv/spc_ctl_test.sv ----
`timescale 1ns/1ps
module spc_ctl_test;
  import spc_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ss_is_input = 1'b0;
  logic ss_pin = 1'b1;
  logic irq_ack = 1'b0;
  logic pact = 1'b0;
  logic plsb = 1'b0;
  logic [1:0] pmode = 2'h0;
  logic [7:0] ptx = 8'h00;
  logic ssck = 1'b0;
  logic smosi = 1'b0;
  logic [7:0] rdata, prx, v;
  logic sck_o, sck_oe, mosi_o, mosi_oe, miso_i, miso_o, miso_oe, irq;
  int errors = 0;
  int comparisons = 0;
  always #2.5 mclk = ~mclk;
  spc_ctl u_dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .ss_is_input(ss_is_input),
    .ss_pin(ss_pin), .irq_ack(irq_ack), .sck_i(ssck), .sck_o(sck_o),
    .sck_oe(sck_oe), .mosi_i(smosi), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
    .miso_i(miso_i), .miso_o(miso_o), .miso_oe(miso_oe), .irq(irq));
  spc_spi_peer u_peer (.mclk(mclk), .active(pact), .mode(pmode),
    .lsb_first(plsb), .sck(sck_o), .mosi(mosi_o), .tx_byte(ptx),
    .miso(miso_i), .rx_byte(prx));
  task automatic tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic over_limit(input int n, input int lim);
    if (n >= lim) begin
      errors++;
      $display("[ERR] %0t wait ran out", $time);
      tally_and_finish();
    end
  endtask
  task automatic poll_flag(input int b);
    int n;
    n = 0;
    rd_reg(A_FLAG, v);
    while (v[b] !== 1'b1 && n < 500) begin
      rd_reg(A_FLAG, v);
      n++;
    end
    over_limit(n, 500);
  endtask
  task automatic slave_byte(input logic [7:0] b);
    // mode 0 far-side master, msb first
    for (int i = 7; i >= 0; i--) begin
      @(posedge mclk);
      smosi <= b[i];
      repeat (4) @(posedge mclk);
      ssck <= 1'b1;
      repeat (4) @(posedge mclk);
      ssck <= 1'b0;
    end
    cycles(6);
    rd_reg(A_FLAG, v);
    check(v, 8'h80);
    rd_reg(A_DATA, v);
    check(v, b);
    check({7'h00, miso_o}, {7'h00, b[7]});
  endtask
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      cycles(1);
      n++;
    end
    if (n >= 3000) begin
      errors++;
      $display("[ERR] %0t wait for irq ran out", $time);
      tally_and_finish();
    end
  endtask
  task automatic t_regs;
    for (int a = 0; a < 4; a++) begin
      rd_reg(3'(a), v);
      check(v, REG_RST);
    end
    wr_reg(A_CORE, 8'hFF);
    rd_reg(A_CORE, v);
    check(v, 8'h77);
    wr_reg(A_MODE, 8'hFF);
    rd_reg(A_MODE, v);
    check(v, 8'hC7);
    wr_reg(A_MODE, 8'h00);
    wr_reg(A_IEN, 8'hFF);
    rd_reg(A_IEN, v);
    check(v, 8'h01);
    wr_reg(3'h6, 8'hFF);
    rd_reg(3'h6, v);
    check(v, 8'h00);
    wr_reg(A_CORE, 8'h00);
  endtask
  task automatic xfer(input logic [7:0] core, input logic [1:0] md,
                      input logic [7:0] tx, input logic [7:0] rx);
    pmode = md;
    plsb = core[6];
    ptx = rx;
    wr_reg(A_MODE, {6'h00, md});
    wr_reg(A_IEN, 8'h01);
    wr_reg(A_CORE, core);
    cycles(2);
    check({7'h00, sck_o}, {7'h00, md[1]});
    pact = 1'b1;
    wr_reg(A_DATA, tx);
    wait_irq();
    rd_reg(A_FLAG, v);
    check(v & 8'h80, 8'h80);
    check(prx, tx);
    rd_reg(A_DATA, v);
    check(v, rx);
    cycles(2);
    check({7'h00, irq}, 8'h00);
    pact = 1'b0;
  endtask
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      xfer(m[0] ? 8'h63 : 8'h23, 2'(m), 8'hA5 ^ 8'(m), 8'h3C + 8'(m));
    end
  endtask
  task automatic t_rate;
    int n;
    logic s0;
    logic [7:0] half;
    for (int c = 0; c < 8; c++) begin
      half = (c / 2 == 3) ? 8'h40 : (8'h02 << (2 * (c / 2)));
      half = half >> (c % 2);
      wr_reg(A_CORE, 8'h21 | 8'((c % 2) << 4) | 8'((c / 2) << 1));
      wr_reg(A_DATA, 8'hC3);
      cycles(1);
      check({6'h00, sck_oe, mosi_oe}, 8'h03);
      for (int k = 0; k < 2; k++) begin
        s0 = sck_o;
        n = 0;
        while (sck_o === s0 && n < 300) begin
          cycles(1);
          n++;
        end
        over_limit(n, 300);
      end
      check(8'(n), half);
      wait_irq();
      @(posedge mclk);
      irq_ack <= 1'b1;
      @(posedge mclk);
      irq_ack <= 1'b0;
      cycles(2);
      check({7'h00, irq}, 8'h00);
    end
  endtask
  task automatic t_collide;
    wr_reg(A_CORE, 8'h23);
    wr_reg(A_DATA, 8'h11);
    wr_reg(A_DATA, 8'h22);
    wait_irq();
    cycles(5);
    check({7'h00, irq}, 8'h01);
    rd_reg(A_FLAG, v);
    check(v, 8'hC0);
    rd_reg(A_DATA, v);
    rd_reg(A_FLAG, v);
    check(v, 8'h00);
  endtask
  task automatic t_fault;
    @(posedge mclk);
    ss_is_input <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      wr_reg(A_MODE, s ? 8'h04 : 8'h00);
      // master role written before SS goes low in each pass
      wr_reg(A_CORE, 8'h23);
      ss_pin <= 1'b0;
      cycles(8);
      rd_reg(A_CORE, v);
      check(v, s ? 8'h23 : 8'h03);
      rd_reg(A_FLAG, v);
      check(v, s ? 8'h00 : 8'h80);
      check({7'h00, irq}, s ? 8'h00 : 8'h01);
      check({6'h00, sck_oe, miso_oe}, s ? 8'h02 : 8'h01);
      rd_reg(A_DATA, v);
      if (s == 0) begin
        slave_byte(8'hB4);
      end
      @(posedge mclk);
      ss_pin <= 1'b1;
      cycles(4);
    end
    @(posedge mclk);
    ss_is_input <= 1'b0;
    wr_reg(A_CORE, 8'h22);
    wr_reg(A_DATA, 8'h55);
    cycles(20);
    check({6'h00, sck_oe, mosi_oe}, 8'h00);
  endtask
  task automatic t_buffered;
    pmode = 2'h0;
    plsb = 1'b0;
    ptx = 8'h5A;
    wr_reg(A_MODE, 8'hC0);
    wr_reg(A_IEN, 8'hFF);
    rd_reg(A_IEN, v);
    check(v, 8'hF1);
    wr_reg(A_CORE, 8'h23);
    rd_reg(A_FLAG, v);
    check(v, 8'h20);
    pact = 1'b1;
    wr_reg(A_DATA, 8'h81);
    wr_reg(A_DATA, 8'h42);
    rd_reg(A_FLAG, v);
    check(v & 8'h20, 8'h00);
    poll_flag(7);
    check(prx, 8'h81);
    wr_reg(A_DATA, 8'h17);
    poll_flag(6);
    check(v, 8'hE1);
    check(prx, 8'h17);
    wr_reg(A_FLAG, 8'hC0);
    rd_reg(A_FLAG, v);
    check(v, 8'h21);
    rd_reg(A_DATA, v);
    check(v, 8'h5A);
    rd_reg(A_DATA, v);
    check(v, 8'h5A);
    rd_reg(A_FLAG, v);
    check(v, 8'h20);
    // dummy byte is the old shifter content
    wr_reg(A_MODE, 8'h80);
    wr_reg(A_DATA, 8'h66);
    poll_flag(7);
    check(prx, 8'h5A);
    poll_flag(6);
    check(prx, 8'h66);
    pact = 1'b0;
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_modes();
    t_rate();
    t_collide();
    t_fault();
    t_buffered();
    tally_and_finish();
  end
endmodule // spc_ctl_test
